// file: occ_pkg.sv
// package: register offsets, field layout, modes and constants of the compare channel
package occ_pkg;

    // ****************************************
    // register map (word index on the plain port)
    // ****************************************
    localparam logic [2:0] OCC_ADDR_CTRL_ONE = 3'h0;
    localparam logic [2:0] OCC_ADDR_CTRL_TWO = 3'h1;
    localparam logic [2:0] OCC_ADDR_PRIMARY = 3'h2;
    localparam logic [2:0] OCC_ADDR_SECONDARY = 3'h3;
    localparam logic [2:0] OCC_ADDR_TIMER = 3'h4;
    localparam logic [2:0] OCC_ADDR_STATUS = 3'h5;

    // ****************************************
    // field positions
    // ****************************************
    localparam int OCC_MODE_LSB = 0;
    localparam int OCC_MODE_W = 3;
    localparam int OCC_SYNC_LSB = 0;
    localparam int OCC_SYNC_W = 5;
    localparam int OCC_TRIG_BIT = 7;
    localparam int OCC_TRIGD_BIT = 6;
    localparam int OCC_STAT_PIN_BIT = 0;
    localparam int OCC_STAT_IRQ_BIT = 1;
    localparam int OCC_SRC_N = 32;

    // ****************************************
    // reset values and codes
    // ****************************************
    localparam logic [15:0] OCC_CMP_RST = 16'h0000;
    localparam logic [15:0] OCC_TMR_ZERO = 16'h0000;
    localparam logic [15:0] OCC_TMR_MAX = 16'hffff;
    localparam logic [4:0] OCC_SYNC_NONE = 5'h00;
    localparam logic [4:0] OCC_SYNC_SELF = 5'h1f;
    localparam int OCC_FLAG_DELAY = 2;

    typedef enum logic [2:0] {
        OCC_MODE_OFF = 3'h0,
        OCC_MODE_SET_HIGH = 3'h1,
        OCC_MODE_SET_LOW = 3'h2,
        OCC_MODE_TOGGLE = 3'h3
    } occ_mode_t;

endpackage

// file: occ_delay.sv
// module: small shift delay line for single-bit pulses
`timescale 1ns/100ps
module occ_delay #(
    parameter int DEPTH = 2
) (
    input wire logic clk, // system clock
    input wire logic sys_rst, // async reset, active high
    input wire logic din, // pulse in
    output logic dout // pulse out, DEPTH cycles later
);
    logic [DEPTH-1:0] pipe_r;

    // plain shift chain; every stage resets to zero
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pipe_r <= '0;
        end else if (DEPTH == 1) begin
            pipe_r <= din;
        end else begin
            pipe_r <= {pipe_r[DEPTH-2:0], din};
        end
    end

    assign dout = pipe_r[DEPTH-1];
endmodule

// file: occ_channel.sv
// module: single output compare channel with timer, sync/trigger and register port
// What this block does
// - synchronous operation: selected source sync pulse clears the channel timer
// - trigger operation: timer held clear until selected source fires
// - trigger mode select sits at bit 7 of control register two
// - sync select zero: no sync source, timer runs freely
// - sync select all ones: timer clears on own secondary compare match
// - own sync output pulses when timer equals secondary compare
// - mode 001: output low on enable, high after primary match
// - mode 010: output high on enable, low after primary match
// - mode 011: output starts at the preset toggle level, inverts on every primary match
// - output change lands two clocks after the primary match
// - set or clear level holds until mode changes or channel off
// - timer counts up, returns to zero the clock after wrap or sync
// - interrupt flag rises two clocks after the output changes
// - interrupt only when a compare event changes the output level
// - output logic clears to zero on reset; software may preset toggle level
// - primary beyond period: no match, output stays at initial level
// - primary equal to period still matches normally
// - primary zero with timer held in reset: output stays initial
// - primary cleared after event, then sync: output keeps new level
// - full 16-bit primary compare, readable and writable
`timescale 1ns/100ps
module occ_channel
    import occ_pkg::*;
(
    input wire logic clk, // system clock, 250 MHz
    input wire logic sys_rst, // async reset, active high
    input wire logic [2:0] reg_addr, // register word index
    input wire logic [15:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [15:0] reg_rdata, // read data, valid cycle after strobe
    input wire logic [OCC_SRC_N-1:0] sync_src_in, // sync pulses from other sources
    output logic compare_output_pin, // compare output pin level
    output logic compare_output_oe, // pin drive enable
    output logic sync_out, // own sync/trigger pulse
    output logic compare_irq_flag // sticky channel interrupt flag
);
    import occ_pkg::*;

    // ****************************************
    // software registers
    // ****************************************
    logic [2:0] mode_r;
    logic tristate_r;
    logic [4:0] sync_source_select_r;
    logic trigger_mode_select_r;
    logic [15:0] primary_compare_r;
    logic [15:0] secondary_compare_r;
    logic [15:0] channel_timer_r;
    logic triggered_r;
    logic out_level_r;
    logic irq_r;
    logic sync_out_r;
    logic [15:0] rdata_r;
    logic preset_level_r;
    logic oe_r;
    logic timer_held;

    logic wr_ctrl_one;
    logic wr_ctrl_two;
    logic mode_change;
    logic sec_match;
    logic pri_match;
    logic ext_sync;
    logic sync_evt;
    logic active;
    logic match_d1_r;
    logic out_nxt;
    logic level_changed;
    logic change_late;
    occ_mode_t mode_now;

    assign wr_ctrl_one = reg_wr && (reg_addr == OCC_ADDR_CTRL_ONE);
    assign wr_ctrl_two = reg_wr && (reg_addr == OCC_ADDR_CTRL_TWO);
    assign mode_change = wr_ctrl_one
        && (reg_wdata[OCC_MODE_LSB +: OCC_MODE_W] != mode_r);
    assign mode_now = occ_mode_t'(mode_r);
    assign active = (mode_now == OCC_MODE_SET_HIGH) || (mode_now == OCC_MODE_SET_LOW)
        || (mode_now == OCC_MODE_TOGGLE);

    // ****************************************
    // control register one: mode, pin direction
    // ****************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_r <= 3'h0;
            tristate_r <= 1'b0;
            oe_r <= 1'b1;
        end else if (wr_ctrl_one) begin
            mode_r <= reg_wdata[OCC_MODE_LSB +: OCC_MODE_W];
            tristate_r <= reg_wdata[5];
            oe_r <= !reg_wdata[5];
        end
    end

    // control register two: sync select and trigger mode select
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync_source_select_r <= OCC_SYNC_NONE;
            trigger_mode_select_r <= 1'b0;
        end else if (wr_ctrl_two) begin
            sync_source_select_r <= reg_wdata[OCC_SYNC_LSB +: OCC_SYNC_W];
            trigger_mode_select_r <= reg_wdata[OCC_TRIG_BIT];
        end
    end

    // compare values, full 16 bits; bit 0 of status write presets toggle level
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            primary_compare_r <= OCC_CMP_RST;
            secondary_compare_r <= OCC_CMP_RST;
            preset_level_r <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == OCC_ADDR_PRIMARY) begin
                primary_compare_r <= reg_wdata;
            end
            if (reg_addr == OCC_ADDR_SECONDARY) begin
                secondary_compare_r <= reg_wdata;
            end
            if (reg_addr == OCC_ADDR_STATUS) begin
                preset_level_r <= reg_wdata[OCC_STAT_PIN_BIT];
            end
        end
    end

    // ****************************************
    // sync / trigger source selection
    // ****************************************
    assign sec_match = (channel_timer_r == secondary_compare_r);
    // a timer parked at zero by a trigger hold or a standing sync is not counting,
    // so a zero primary must not match there
    assign timer_held = (trigger_mode_select_r && !triggered_r)
        || (sync_evt && (channel_timer_r == OCC_TMR_ZERO));
    assign pri_match = active && !timer_held
        && (channel_timer_r == primary_compare_r);

    // source zero never syncs; all ones uses own secondary match
    always_comb begin
        if (sync_source_select_r == OCC_SYNC_NONE) begin
            ext_sync = 1'b0;
        end else if (sync_source_select_r == OCC_SYNC_SELF) begin
            ext_sync = sec_match;
        end else begin
            ext_sync = sync_src_in[sync_source_select_r];
        end
    end

    // trigger mode only ever resets via hold; sync mode clears on pulse
    assign sync_evt = !trigger_mode_select_r && ext_sync;

    // trigger state: cleared on any control register two write or when trigger mode is off
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            triggered_r <= 1'b0;
        end else if (!trigger_mode_select_r || wr_ctrl_two) begin
            triggered_r <= 1'b0;
        end else if (ext_sync || sync_source_select_r == OCC_SYNC_NONE) begin
            triggered_r <= 1'b1;
        end
    end

    // ****************************************
    // channel timer
    // ****************************************
    // wrap falls out of the 16-bit add; sync clears on the following edge
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            channel_timer_r <= OCC_TMR_ZERO;
        end else if (!active) begin
            channel_timer_r <= OCC_TMR_ZERO;
        end else if (trigger_mode_select_r && !triggered_r) begin
            channel_timer_r <= OCC_TMR_ZERO;
        end else if (sync_evt) begin
            channel_timer_r <= OCC_TMR_ZERO;
        end else begin
            channel_timer_r <= channel_timer_r + 16'h0001;
        end
    end

    // own sync pulse, registered so the port comes from a flop
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync_out_r <= 1'b0;
        end else begin
            sync_out_r <= active && sec_match;
        end
    end

    // ****************************************
    // compare output
    // ****************************************
    // match registered once, so the pin moves two clocks after the match
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            match_d1_r <= 1'b0;
        end else begin
            match_d1_r <= pri_match && !mode_change;
        end
    end

    // next pin level; a repeated set or clear of an already-set level
    // produces no change, so no flag either
    always_comb begin
        out_nxt = out_level_r;
        unique case (mode_now)
            OCC_MODE_SET_HIGH: begin
                if (match_d1_r) begin
                    out_nxt = 1'b1;
                end
            end
            OCC_MODE_SET_LOW: begin
                if (match_d1_r) begin
                    out_nxt = 1'b0;
                end
            end
            OCC_MODE_TOGGLE: begin
                if (match_d1_r) begin
                    out_nxt = !out_level_r;
                end
            end
            default: begin
                out_nxt = 1'b0;
            end
        endcase
    end

    // enable applies initial level; otherwise pin follows out_nxt
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            out_level_r <= 1'b0;
        end else if (mode_change) begin
            unique case (occ_mode_t'(reg_wdata[OCC_MODE_LSB +: OCC_MODE_W]))
                OCC_MODE_SET_HIGH: out_level_r <= 1'b0;
                OCC_MODE_SET_LOW: out_level_r <= 1'b1;
                OCC_MODE_TOGGLE: out_level_r <= preset_level_r;
                default: out_level_r <= 1'b0;
            endcase
        end else begin
            out_level_r <= out_nxt;
        end
    end

    // ****************************************
    // interrupt flag
    // ****************************************
    // only a real level change counts; a held timer repeating a set does not
    assign level_changed = match_d1_r && !mode_change && (out_nxt != out_level_r);

    occ_delay #(
        .DEPTH(OCC_FLAG_DELAY)
    ) u_flag_delay (
        .clk(clk),
        .sys_rst(sys_rst),
        .din(level_changed),
        .dout(change_late)
    );

    // sticky flag; set wins over a software clear in the same cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_r <= 1'b0;
        end else if (change_late) begin
            irq_r <= 1'b1;
        end else if (reg_wr && reg_addr == OCC_ADDR_STATUS
                     && reg_wdata[OCC_STAT_IRQ_BIT]) begin
            irq_r <= 1'b0;
        end
    end

    // ****************************************
    // read port
    // ****************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_r <= 16'h0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                OCC_ADDR_CTRL_ONE: rdata_r <= {10'h000, tristate_r, 2'h0, mode_r};
                OCC_ADDR_CTRL_TWO: rdata_r <= {8'h00, trigger_mode_select_r,
                    triggered_r, 1'b0, sync_source_select_r};
                OCC_ADDR_PRIMARY: rdata_r <= primary_compare_r;
                OCC_ADDR_SECONDARY: rdata_r <= secondary_compare_r;
                OCC_ADDR_TIMER: rdata_r <= channel_timer_r;
                OCC_ADDR_STATUS: rdata_r <= {7'h00, preset_level_r, 6'h00,
                    irq_r, out_level_r};
                default: rdata_r <= 16'h0000;
            endcase
        end else begin
            rdata_r <= 16'h0000;
        end
    end

    assign reg_rdata = rdata_r;
    assign compare_output_pin = out_level_r;
    assign compare_output_oe = oe_r;
    assign sync_out = sync_out_r;
    assign compare_irq_flag = irq_r;
endmodule

// file: occ_sync_model.sv
// model: external sync and trigger sources feeding the compare channel
`timescale 1ns/100ps
module occ_sync_model
    import occ_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic sys_rst, // async reset, active high
    input wire logic fire, // request one pulse
    input wire logic [4:0] src_sel, // source code that pulses
    output logic [OCC_SRC_N-1:0] sync_src_in // one line per source
);
    // ****************************************
    // pulse generator
    // ****************************************
    // one-cycle pulse on the chosen line only; idle lines sit low, as a real source would
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync_src_in <= '0;
        end else begin
            sync_src_in <= fire ? (32'h0000_0001 << src_sel) : '0;
        end
    end
endmodule

// file: occ_channel_chk.sv
// checker: port-level properties of the compare channel
`timescale 1ns/100ps
module occ_channel_chk
    import occ_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic sys_rst, // async reset
    input wire logic [2:0] reg_addr, // register index
    input wire logic [15:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic [15:0] reg_rdata, // read data
    input wire logic [OCC_SRC_N-1:0] sync_src_in, // sync pulses
    input wire logic compare_output_pin, // pin level
    input wire logic compare_output_oe, // pin drive enable
    input wire logic sync_out, // own sync pulse
    input wire logic compare_irq_flag // interrupt flag
);
    logic [2:0] mode_r;
    logic [4:0] sel_r;
    logic clr_req;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ****************************************
    // shadow of the last written mode and sync select
    // ****************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_r <= 3'h0;
            sel_r <= 5'h00;
        end else if (reg_wr && reg_addr == OCC_ADDR_CTRL_ONE) begin
            mode_r <= reg_wdata[2:0];
        end else if (reg_wr && reg_addr == OCC_ADDR_CTRL_TWO) begin
            sel_r <= reg_wdata[4:0];
        end
    end
    // flag clear request, kept as a net so $past sees a plain signal
    assign clr_req = reg_wr && reg_addr == OCC_ADDR_STATUS && reg_wdata[1];
    // write, one idle cycle, then read of the same word
    sequence wr_rd(a);
        reg_wr && reg_addr == a ##2 reg_rd && reg_addr == a;
    endsequence
    sequence rd_twice;
        reg_rd && reg_addr == OCC_ADDR_TIMER && $stable(mode_r) ##1
        reg_rd && reg_addr == OCC_ADDR_TIMER && sel_r == 5'h00 && mode_r inside {[3'h1:3'h3]};
    endsequence
    primary_rw_a: assert property (wr_rd(OCC_ADDR_PRIMARY) |=>
        reg_rdata == $past(reg_wdata, 3)) else $error("primary readback wrong");
    trig_bit_a: assert property (wr_rd(OCC_ADDR_CTRL_TWO) |=>
        (reg_rdata & 16'h009f) == ($past(reg_wdata, 3) & 16'h009f))
        else $error("control two readback wrong");
    timer_count_a: assert property (rd_twice |=>
        reg_rdata == $past(reg_rdata) + 16'h0001) else $error("timer did not count by one");
    hold_high_a: assert property (mode_r == 3'h1 && $past(mode_r) == 3'h1 &&
        compare_output_pin && !(reg_wr && reg_addr == OCC_ADDR_CTRL_ONE)
        |=> compare_output_pin) else $error("set level lost");
    hold_low_a: assert property (mode_r == 3'h2 && $past(mode_r) == 3'h2 &&
        !compare_output_pin && !(reg_wr && reg_addr == OCC_ADDR_CTRL_ONE)
        |=> !compare_output_pin) else $error("clear level lost");
    irq_after_pin_a: assert property ($rose(compare_irq_flag) |->
        $past(compare_output_pin, 2) != $past(compare_output_pin, 3))
        else $error("flag rose without pin change two clocks before");
    flag_clear_a: assert property ($fell(compare_irq_flag) |-> $past(clr_req))
        else $error("flag dropped without clear");
    read_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data outside read cycle");
endmodule

// file: test_occ_channel.sv
// testbench: register-driven scenarios for the compare channel
`timescale 1ns/100ps
module test_occ_channel;
    import occ_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic fire = 1'b0;
    logic [4:0] src_sel = 5'h05;
    logic [15:0] reg_rdata, rv, t1, t2, tog, nsy;
    logic [OCC_SRC_N-1:0] sync_src_in;
    logic compare_output_pin, compare_output_oe, sync_out, compare_irq_flag, prev;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n;
    always #2 clk = ~clk;
    occ_channel dut_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sync_src_in(sync_src_in), .compare_output_pin(compare_output_pin),
        .compare_output_oe(compare_output_oe), .sync_out(sync_out),
        .compare_irq_flag(compare_irq_flag));
    occ_sync_model src_u (.clk(clk), .sys_rst(sys_rst), .fire(fire), .src_sel(src_sel),
        .sync_src_in(sync_src_in));
    // ****************************************
    // access tasks and checks
    // ****************************************
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // writes leave an idle cycle so a strobe is never lowered and raised in one step
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [2:0] a, output logic [15:0] v);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
        @(posedge clk);
    endtask
    // two back-to-back timer reads
    task automatic rd2();
        reg_addr <= OCC_ADDR_TIMER;
        reg_rd <= 1'b1;
        @(posedge clk);
        #1 t1 = reg_rdata;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 t2 = reg_rdata;
        @(posedge clk);
    endtask
    task automatic wait_pin(input logic lv);
        n = 0;
        while (compare_output_pin !== lv && n < 100) begin
            @(posedge clk);
            #1 n++;
        end
    endtask
    task automatic mode_run(input logic [2:0] m, input logic init, input logic fin);
        wr(OCC_ADDR_CTRL_ONE, 16'h0000);
        wr(OCC_ADDR_STATUS, 16'h0002);
        wr(OCC_ADDR_CTRL_ONE, {13'h0000, m});
        #1 chk("pin on enable", 16'(compare_output_pin), 16'(init));
        chk("flag on enable", 16'(compare_irq_flag), 16'h0000);
        wait_pin(fin);
        chk("pin after match", 16'(compare_output_pin), 16'(fin));
        @(posedge clk);
        #1 chk("flag one clock", 16'(compare_irq_flag), 16'h0000);
        @(posedge clk);
        #1 chk("flag two clocks", 16'(compare_irq_flag), 16'h0001);
        repeat (30) @(posedge clk);
        #1 chk("pin held", 16'(compare_output_pin), 16'(fin));
    endtask
    task automatic count40();
        tog = 16'h0000;
        nsy = 16'h0000;
        repeat (8) @(posedge clk);
        #1 prev = compare_output_pin;
        repeat (40) begin
            @(posedge clk);
            #1 tog = tog + 16'(compare_output_pin !== prev);
            nsy = nsy + 16'(sync_out === 1'b1);
            prev = compare_output_pin;
        end
    endtask
    task automatic pulse();
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
    endtask
    // hang guard, well above the few hundred cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            summarize();
        end
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1 chk("pin reset", 16'(compare_output_pin), 16'h0000);
        chk("oe reset", 16'(compare_output_oe), 16'h0001);
        rd(OCC_ADDR_PRIMARY, rv);
        chk("primary reset", rv, OCC_CMP_RST);
        wr(OCC_ADDR_PRIMARY, 16'hbeef);
        rd(OCC_ADDR_PRIMARY, rv);
        chk("primary", rv, 16'hbeef);
        rd(3'h6, rv);
        chk("unmapped", rv, 16'h0000);
        wr(OCC_ADDR_CTRL_ONE, 16'h0020);
        #1 chk("oe tristate", 16'(compare_output_oe), 16'h0000);
        wr(OCC_ADDR_CTRL_ONE, 16'h0000);
        #1 chk("oe driven", 16'(compare_output_oe), 16'h0001);
        wr(OCC_ADDR_PRIMARY, 16'h0008);
        mode_run(3'h1, 1'b0, 1'b1);
        rd2();
        chk("timer step", t2, t1 + 16'h0001);
        mode_run(3'h2, 1'b1, 1'b0);
        mode_run(3'h3, 1'b0, 1'b1);
        wr(OCC_ADDR_CTRL_ONE, 16'h0000);
        wr(OCC_ADDR_SECONDARY, 16'h0003);
        wr(OCC_ADDR_PRIMARY, 16'h0003);
        wr(OCC_ADDR_CTRL_TWO, 16'h001f);
        wr(OCC_ADDR_CTRL_ONE, 16'h0003);
        count40();
        chk("square toggles", tog, 16'h000a);
        chk("own sync pulses", nsy, 16'h000a);
        wr(OCC_ADDR_CTRL_ONE, 16'h0000);
        wr(OCC_ADDR_PRIMARY, 16'h0004);
        wr(OCC_ADDR_CTRL_ONE, 16'h0001);
        count40();
        chk("beyond period", tog, 16'h0000);
        wr(OCC_ADDR_CTRL_ONE, 16'h0000);
        wr(OCC_ADDR_PRIMARY, 16'h0040);
        wr(OCC_ADDR_CTRL_TWO, 16'h0005);
        wr(OCC_ADDR_CTRL_ONE, 16'h0001);
        repeat (6) begin
            repeat (19) @(posedge clk);
            pulse();
        end
        #1 chk("sync keeps timer low", 16'(compare_output_pin), 16'h0000);
        wr(OCC_ADDR_CTRL_ONE, 16'h0000);
        wr(OCC_ADDR_PRIMARY, 16'h0000);
        wr(OCC_ADDR_CTRL_TWO, 16'h0085);
        rd(OCC_ADDR_CTRL_TWO, rv);
        chk("trigger armed", rv, 16'h0085);
        wr(OCC_ADDR_CTRL_ONE, 16'h0001);
        repeat (10) @(posedge clk);
        rd(OCC_ADDR_TIMER, rv);
        chk("timer held", rv, 16'h0000);
        #1 chk("held pin", 16'(compare_output_pin), 16'h0000);
        pulse();
        repeat (4) @(posedge clk);
        rd(OCC_ADDR_CTRL_TWO, rv);
        chk("triggered", rv, 16'h00c5);
        rd2();
        chk("runs after trigger", t2, t1 + 16'h0001);
        wr(OCC_ADDR_CTRL_ONE, 16'h0000);
        wr(OCC_ADDR_STATUS, 16'h0001);
        wr(OCC_ADDR_CTRL_ONE, 16'h0003);
        #1 chk("toggle preset", 16'(compare_output_pin), 16'h0001);
        summarize();
    end
endmodule
bind occ_channel occ_channel_chk chk_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sync_src_in(sync_src_in), .compare_output_pin(compare_output_pin),
    .compare_output_oe(compare_output_oe), .sync_out(sync_out),
    .compare_irq_flag(compare_irq_flag));
